/* File: wkirq_pkg.sv */
package wkirq_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry and offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] PIN_WAKE_OFS    = 12'h064;
    localparam logic [11:0] INTERRUPT_ENDPOINT_CONTROL_OFS  = 12'h068;
    localparam logic [11:0] IRQ_STATUS_OFS  = 12'h0f0;
    localparam logic [11:0] IRQ_CLEAR_OFS   = 12'h0f4;
    localparam logic [11:0] IRQ_ENABLE_OFS  = 12'h0f8;

    // ------------------------------------------------------------------
    // Field layout of the pin wake enable and polarity register
    // ------------------------------------------------------------------
    localparam int          NUM_PINS        = 11;
    localparam int          WAKE_EN_LSB     = 0;
    localparam int          POL_LSB         = 16;
    localparam int          LINK_UP_BIT     = 31;
    localparam int          LINK_PIN        = 7;

    // ------------------------------------------------------------------
    // Field layout of the interrupt endpoint control register
    // ------------------------------------------------------------------
    localparam int          NUM_SRC         = 9;
    localparam int          PIN_IRQ_LSB     = 0;
    localparam int          SRC_LSB         = 11;
    localparam int          EV_W            = 20;
    localparam int          ALWAYS_ON_BIT   = 31;
    // Source order from bit 11 upward
    localparam int          SRC_RX_DROP     = 0;
    localparam int          SRC_TXF_OVER    = 1;
    localparam int          SRC_TXF_UNDER   = 2;
    localparam int          SRC_TX_ERR      = 3;
    localparam int          SRC_PHY         = 4;
    localparam int          SRC_RX_HALT     = 5;
    localparam int          SRC_TX_HALT     = 6;
    localparam int          SRC_RX_FRAME    = 7;
    localparam int          SRC_MAC_RTO     = 8;

    // ------------------------------------------------------------------
    // Local interrupt status layout and reset values
    // ------------------------------------------------------------------
    localparam int          IRQ_BITS        = 2;
    localparam int          IRQ_WAKE_BIT    = 0;
    localparam int          IRQ_PKT_BIT     = 1;
    localparam logic [10:0] WAKE_EN_RST     = 11'h000;
    localparam logic [10:0] POL_RST         = 11'h000;
    localparam logic [19:0] EP_EN_RST       = 20'h00000;
    localparam logic [1:0]  IRQ_RST         = 2'h0;

endpackage : wkirq_pkg

/* File: wkirq_pin_detect.sv */
`timescale 1ns/100ps

module wkirq_pin_detect #(
    parameter int N = wkirq_pkg::NUM_PINS
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Pin state and setup
    input  wire logic [N-1:0] pin_i,
    input  wire logic [N-1:0] is_gpio_i,
    input  wire logic [N-1:0] pol_i,
    // Detected level events
    output logic      [N-1:0] evt_o
);

    // ------------------------------------------------------------------
    // Per-pin level match
    // ------------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_pin
        // Level event only while the pin serves as general-purpose I/O
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                evt_o[g] <= 1'b0;
            end else begin
                evt_o[g] <= is_gpio_i[g] & (pin_i[g] == pol_i[g]);
            end
        end
    end

endmodule : wkirq_pin_detect

/* File: wkirq_pending.sv */
`timescale 1ns/100ps

module wkirq_pending #(
    parameter int W = wkirq_pkg::EV_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Enabled events and report strobe
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_i,
    // Held events
    output logic      [W-1:0] pend_o
);

    // ------------------------------------------------------------------
    // Sticky hold between endpoint intervals
    // ------------------------------------------------------------------
    // A new event in the reporting cycle survives to the next packet
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_o <= '0;
        end else begin
            pend_o <= (pend_o & ~{W{clr_i}}) | set_i;
        end
    end

endmodule : wkirq_pending

/* File: wkirq_top.sv */
`timescale 1ns/100ps

// Function
// - Bits 10:0 enable per-pin wake
// - Bits 26:16 select per-pin trigger level
// - Non-GPIO pins never wake
// - Bit 31 arms pin 7 link-up wake
// - Wake enables default from EEPROM image
// - USB or lite reset restores image
// - Wake enables obey reset protection
// - Bit 31 sends packet every interval
// - Bits 19:16 gate RX/TX halt, RX frame, MAC timeout
// - Bits 15:14 gate PHY, TX error
// - Bits 13:12 gate TX FIFO faults
// - Bit 11 gates dropped receive frames
// - Bits 10:0 gate pin interrupt events
module wkirq_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [11:0] addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // Pins and their function select
    input  wire logic [10:0] gpio_in_i,
    input  wire logic [10:0] gpio_is_gpio_i,
    // Device event sources, bit order as control bits 19:11
    input  wire logic [8:0]  src_event_i,
    // Device state and reset requests
    input  wire logic        suspend_state_zero_i,
    input  wire logic        suspend_state_three_i,
    input  wire logic        usb_reset_i,
    input  wire logic        lite_soft_reset_i,
    input  wire logic        reset_protect_i,
    // EEPROM image load
    input  wire logic        eeprom_load_i,
    input  wire logic [15:0] eeprom_wake_i,
    // Interrupt endpoint
    input  wire logic        ep_interval_i,
    output logic             pkt_send_o,
    output logic      [19:0] pkt_status_o,
    // Wake and local interrupt
    output logic             wake_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [10:0] wake_en_q;
    logic [10:0] pol_q;
    logic        link_en_q;
    logic [19:0] ep_en_q;
    logic        always_on_q;
    logic [10:0] image_q;
    logic [1:0]  sts_q;
    logic [1:0]  sts_d;
    logic [1:0]  irq_en_q;
    logic [31:0] rdata_d;
    logic [10:0] pin_evt;
    logic [19:0] pend;
    logic [19:0] ev_masked;
    logic        link_arm;
    logic        wake_d;
    logic        pkt_d;
    logic        wr_pin;
    logic        wr_ctl;
    logic        wr_clr;
    logic        wr_ien;
    logic        rst_req;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Plain compare; the slave never stalls the master
    assign wr_pin  = wr_i && (addr_i == wkirq_pkg::PIN_WAKE_OFS);
    assign wr_ctl  = wr_i && (addr_i == wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS);
    assign wr_clr  = wr_i && (addr_i == wkirq_pkg::IRQ_CLEAR_OFS);
    assign wr_ien  = wr_i && (addr_i == wkirq_pkg::IRQ_ENABLE_OFS);
    assign rst_req = usb_reset_i | lite_soft_reset_i;

    // ------------------------------------------------------------------
    // EEPROM image of the wake enables
    // ------------------------------------------------------------------
    // image keeps low bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            image_q <= wkirq_pkg::WAKE_EN_RST;
        end else if (eeprom_load_i) begin
            image_q <= eeprom_wake_i[10:0]; // High unused bits dropped
        end
    end

    // ------------------------------------------------------------------
    // Wake enable field
    // ------------------------------------------------------------------
    // Load beats reset restore, which beats a software write. Without an
    // EEPROM the image stays zero, so a restore clears the field.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_en_q <= wkirq_pkg::WAKE_EN_RST;
        end else if (eeprom_load_i) begin
            wake_en_q <= eeprom_wake_i[10:0];
        end else if (rst_req && !reset_protect_i) begin
            wake_en_q <= image_q;
        end else if (rst_req) begin
            wake_en_q <= wake_en_q;
        end else if (wr_pin) begin
            wake_en_q <= wr_data_i[wkirq_pkg::WAKE_EN_LSB +: wkirq_pkg::NUM_PINS];
        end
    end

    // ------------------------------------------------------------------
    // Polarity and link-up enable
    // ------------------------------------------------------------------
    // per-pin polarity store
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pol_q     <= wkirq_pkg::POL_RST;
            link_en_q <= 1'b0;
        end else if (wr_pin) begin
            pol_q     <= wr_data_i[wkirq_pkg::POL_LSB +: wkirq_pkg::NUM_PINS];
            link_en_q <= wr_data_i[wkirq_pkg::LINK_UP_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt endpoint control
    // ------------------------------------------------------------------
    // enables reset to zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ep_en_q     <= wkirq_pkg::EP_EN_RST;
            always_on_q <= 1'b0;
        end else if (wr_ctl) begin
            ep_en_q     <= wr_data_i[wkirq_pkg::EV_W-1:0];
            always_on_q <= wr_data_i[wkirq_pkg::ALWAYS_ON_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Pin level detection
    // ------------------------------------------------------------------
    // level match per pin
    wkirq_pin_detect #(
        .N         (wkirq_pkg::NUM_PINS)
    ) u_detect (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (gpio_in_i),
        .is_gpio_i (gpio_is_gpio_i),
        .pol_i     (pol_q),
        .evt_o     (pin_evt)
    );

    // ------------------------------------------------------------------
    // Wake generation
    // ------------------------------------------------------------------
    // link-up in suspend
    assign link_arm = link_en_q & (suspend_state_zero_i | suspend_state_three_i);
    assign wake_d   = (|(pin_evt & wake_en_q)) | (link_arm & pin_evt[wkirq_pkg::LINK_PIN]);

    // Wake is a level; it follows the pin while the match holds
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= wake_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt packet sources
    // ------------------------------------------------------------------
    // Source and pin event gates
    assign ev_masked = {src_event_i, pin_evt} & ep_en_q;

    wkirq_pending #(
        .W       (wkirq_pkg::EV_W)
    ) u_pending (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (ev_masked),
        .clr_i   (pkt_d),
        .pend_o  (pend)
    );

    // ------------------------------------------------------------------
    // Packet issue at the endpoint interval
    // ------------------------------------------------------------------
    // always-on or pending
    assign pkt_d = ep_interval_i && (always_on_q || (pend != '0));

    // Status is a snapshot; later events go to the next packet
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pkt_send_o   <= 1'b0;
            pkt_status_o <= '0;
        end else begin
            pkt_send_o <= pkt_d;
            if (pkt_d) begin
                pkt_status_o <= pend;
            end
        end
    end

    // ------------------------------------------------------------------
    // Local interrupt status, clear and enable
    // ------------------------------------------------------------------
    // Set wins over a clear in the same cycle
    always_comb begin
        sts_d = sts_q & ~(wr_clr ? wr_data_i[1:0] : 2'h0);
        sts_d[wkirq_pkg::IRQ_WAKE_BIT] = sts_d[wkirq_pkg::IRQ_WAKE_BIT] | (wake_d & ~wake_o);
        sts_d[wkirq_pkg::IRQ_PKT_BIT]  = sts_d[wkirq_pkg::IRQ_PKT_BIT] | pkt_d;
    end

    // Status, enable and the interrupt level itself
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sts_q    <= wkirq_pkg::IRQ_RST;
            irq_en_q <= wkirq_pkg::IRQ_RST;
            irq_o    <= 1'b0;
        end else begin
            sts_q <= sts_d;
            if (wr_ien) begin
                irq_en_q <= wr_data_i[wkirq_pkg::IRQ_BITS-1:0];
            end
            irq_o <= |(sts_d & (wr_ien ? wr_data_i[1:0] : irq_en_q));
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped, write-only and idle cycles read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                wkirq_pkg::PIN_WAKE_OFS: begin
                    rdata_d[wkirq_pkg::WAKE_EN_LSB +: wkirq_pkg::NUM_PINS] = wake_en_q;
                    rdata_d[wkirq_pkg::POL_LSB +: wkirq_pkg::NUM_PINS]     = pol_q;
                    rdata_d[wkirq_pkg::LINK_UP_BIT]                        = link_en_q;
                end
                wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS: begin
                    rdata_d[wkirq_pkg::EV_W-1:0]       = ep_en_q;
                    rdata_d[wkirq_pkg::ALWAYS_ON_BIT]  = always_on_q;
                end
                wkirq_pkg::IRQ_STATUS_OFS: begin
                    rdata_d[wkirq_pkg::IRQ_BITS-1:0] = sts_q;
                end
                wkirq_pkg::IRQ_ENABLE_OFS: begin
                    rdata_d[wkirq_pkg::IRQ_BITS-1:0] = irq_en_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // One-cycle read latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 32'h0000_0000;
        end else begin
            rd_data_o <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Two quiet cycles with no pin in GPIO mode and no link arm
    sequence no_cause_s;
        ((gpio_is_gpio_i == 11'h000) && !link_arm) [*2];
    endsequence

    // A restore request that is neither protected nor overridden
    sequence restore_s;
        rst_req && !reset_protect_i && !eeprom_load_i;
    endsequence

    // Interval tick with nothing held and no always-on
    sequence idle_tick_s;
        ep_interval_i && !always_on_q && (pend == 20'h00000);
    endsequence

    mode_gate_a: assert property (no_cause_s |=> !wake_o)
        else $error("wake raised with no GPIO pin and no link arm");

    level_match_a: assert property (
        pin_evt[0] == $past(gpio_is_gpio_i[0] && (gpio_in_i[0] == pol_q[0])))
        else $error("pin 0 event disagrees with polarity");

    pin_wake_a: assert property (
        (pin_evt[3] && wake_en_q[3]) |=> wake_o)
        else $error("enabled pin 3 match did not wake");

    link_wake_a: assert property (
        (link_arm && pin_evt[wkirq_pkg::LINK_PIN]) |=> wake_o)
        else $error("link-up on pin 7 in suspend did not wake");

    eeprom_load_a: assert property (
        eeprom_load_i |=> (wake_en_q == $past(eeprom_wake_i[10:0])))
        else $error("wake enables not loaded from EEPROM image");

    restore_img_a: assert property (
        restore_s |=> (wake_en_q == $past(image_q)))
        else $error("reset did not restore wake enable image");

    protect_hold_a: assert property (
        (rst_req && reset_protect_i && !eeprom_load_i) |=> $stable(wake_en_q))
        else $error("protected wake enables changed on reset");

    always_on_a: assert property (
        (ep_interval_i && always_on_q) |=> pkt_send_o)
        else $error("always-on interval sent no packet");

    idle_quiet_a: assert property (idle_tick_s |=> !pkt_send_o)
        else $error("packet sent with nothing pending");

    src_gate_a: assert property (
        ((pend & ~$past(pend)) & ~$past(ep_en_q)) == 20'h00000)
        else $error("disabled source became pending");

    pend_hold_a: assert property (
        ((pend != 20'h00000) && !ep_interval_i) |=> ((pend & $past(pend)) == $past(pend)))
        else $error("pending event lost between intervals");

    report_a: assert property (
        (ep_interval_i && pend[12]) |=> (pkt_send_o && pkt_status_o[12]))
        else $error("held event missing from next packet");

endmodule : wkirq_top

/* File: wkirq_host_model.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Host side of the interrupt endpoint
// ------------------------------------------------------------------
module wkirq_host_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Poll request and its delay in cycles
    input  wire logic       poll_req_i,
    input  wire logic [3:0] poll_dly_i,
    // Interval tick towards the endpoint
    output logic            ep_interval_o
);
    logic [4:0] cnt_q;

    // A delay lets the host poll late, so held events must wait for it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q         <= 5'h00;
            ep_interval_o <= 1'b0;
        end else begin
            ep_interval_o <= (cnt_q == 5'h01);  // One moment per interval
            if (poll_req_i) begin
                cnt_q <= {1'b0, poll_dly_i} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule : wkirq_host_model

/* File: wkirq_top_tb.sv */
`timescale 1ns/100ps

module wkirq_top_tb;
    logic        clk_i, rst_n_i, wr_i, rd_i, pkt_send_o, wake_o, irq_o, p;
    logic        susp0, susp3, usb_rst, lite_rst, protect, ee_load, ep_tick, poll_req;
    logic        rd_seen_q = 1'b0;
    logic [11:0] addr_i;
    logic [31:0] wr_data_i, rd_data_o, seed;
    logic [10:0] gpio_in_i, gpio_is_gpio_i;
    logic [8:0]  src_event_i;
    logic [15:0] ee_img;
    logic [3:0]  poll_dly;
    logic [19:0] pkt_status_o;
    logic [31:0] exp_rd[$];
    logic [19:0] exp_pkt[$];
    int          n_mismatch = 0;
    int          comparisons = 0;

    wkirq_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .gpio_in_i(gpio_in_i),
        .gpio_is_gpio_i(gpio_is_gpio_i), .src_event_i(src_event_i),
        .suspend_state_zero_i(susp0), .suspend_state_three_i(susp3), .usb_reset_i(usb_rst),
        .lite_soft_reset_i(lite_rst), .reset_protect_i(protect), .eeprom_load_i(ee_load),
        .eeprom_wake_i(ee_img), .ep_interval_i(ep_tick), .pkt_send_o(pkt_send_o),
        .pkt_status_o(pkt_status_o), .wake_o(wake_o), .irq_o(irq_o));

    wkirq_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .poll_req_i(poll_req),
        .poll_dly_i(poll_dly), .ep_interval_o(ep_tick));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : report

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask : cmp_rd

    task automatic cmp_pkt(input logic [19:0] got, input logic [19:0] exp);
        report({12'h000, got}, {12'h000, exp});
    endtask : cmp_pkt

    task automatic cmp_lvl(input logic got, input logic exp);
        report({31'h0, got}, {31'h0, exp});
    endtask : cmp_lvl

    // One access then an idle cycle, so no strobe is set twice in one step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        wr_i      <= wr;
        rd_i      <= !wr;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        exp_rd.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Level outputs are looked at mid-cycle, well after their edge
    task automatic chk(input logic sel, input logic e);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        cmp_lvl(sel ? irq_o : wake_o, e);
        @(posedge clk_i);
    endtask : chk

    // Pins idle high with polarity 0, so a low cycle is one pin event
    task automatic fire(input logic [19:0] ev);
        gpio_in_i   <= ~ev[10:0];
        src_event_i <= ev[19:11];
        @(posedge clk_i);
        gpio_in_i   <= 11'h7ff;
        src_event_i <= 9'h000;
        repeat (3) @(posedge clk_i);
    endtask : fire

    task automatic poll(input logic [3:0] d);
        poll_req <= 1'b1;
        poll_dly <= d;
        @(posedge clk_i);
        poll_req <= 1'b0;
        repeat (d + 6) @(posedge clk_i);
    endtask : poll

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        rd_seen_q <= rd_i;
        if (rd_seen_q) begin
            cmp_rd(rd_data_o, exp_rd.pop_front());
        end
        if (pkt_send_o === 1'b1) begin
            cmp_pkt(pkt_status_o, exp_pkt.size() > 0 ? exp_pkt.pop_front() : 20'hfffff);
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n_i, wr_i, rd_i, susp0, susp3, usb_rst, lite_rst, protect, ee_load} = '0;
        {poll_req, poll_dly, addr_i, wr_data_i, src_event_i, ee_img} = '0;
        gpio_in_i      = 11'h000;
        gpio_is_gpio_i = 11'h000;
        seed           = 32'd83013;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h0);
        rd(wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, 32'h0);
        rd(12'h100, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, seed);
            rd(wkirq_pkg::PIN_WAKE_OFS, seed & 32'h87ff07ff);
            bus(1'b1, wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, ~seed);
            rd(wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, ~seed & 32'h800fffff);
        end
        bus(1'b1, wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, 32'h0);
        gpio_is_gpio_i <= 11'h7ff;
        // Each pin alone: level match, mismatch, other function, wake disabled
        for (int n = 0; n < 11; n++) begin
            seed = lfsr(seed);
            p    = seed[0];
            bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, (32'(p) << (16 + n)) | (32'h1 << n));
            gpio_in_i <= p ? (11'h1 << n) : ~(11'h1 << n);
            chk(1'b0, 1'b1);
            gpio_in_i <= ~gpio_in_i;
            chk(1'b0, 1'b0);
            gpio_in_i      <= ~gpio_in_i;
            gpio_is_gpio_i <= ~(11'h1 << n);
            chk(1'b0, 1'b0);
            gpio_is_gpio_i <= 11'h7ff;
            bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'(p) << (16 + n));
            chk(1'b0, 1'b0);
        end
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h8080_0000);
        gpio_in_i <= 11'h080;
        chk(1'b0, 1'b0);
        susp0 <= 1'b1;
        chk(1'b0, 1'b1);
        susp0 <= 1'b0;
        susp3 <= 1'b1;
        chk(1'b0, 1'b1);
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h0080_0000);
        chk(1'b0, 1'b0);
        rd(wkirq_pkg::IRQ_STATUS_OFS, 32'h1);
        susp3          <= 1'b0;
        gpio_is_gpio_i <= 11'h000;
        // No image loaded yet, so a restore must clear the field
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h0080_0005);
        usb_rst <= 1'b1;
        @(posedge clk_i);
        usb_rst <= 1'b0;
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h0080_0000);
        ee_img         <= 16'hfabc;
        ee_load        <= 1'b1;
        @(posedge clk_i);
        ee_load <= 1'b0;
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h0080_02bc);
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h00ff_0005);
        usb_rst <= 1'b1;
        @(posedge clk_i);
        usb_rst <= 1'b0;
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h00ff_02bc);
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h00ff_0005);
        protect  <= 1'b1;
        lite_rst <= 1'b1;
        @(posedge clk_i);
        lite_rst <= 1'b0;
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h00ff_0005);
        protect  <= 1'b0;
        lite_rst <= 1'b1;
        @(posedge clk_i);
        lite_rst <= 1'b0;
        rd(wkirq_pkg::PIN_WAKE_OFS, 32'h00ff_02bc);
        bus(1'b1, wkirq_pkg::PIN_WAKE_OFS, 32'h0);
        gpio_in_i      <= 11'h7ff;
        gpio_is_gpio_i <= 11'h7ff;
        // Every enable alone, with a disabled event beside it and a poll delayed by k mod 16 cycles
        for (int k = 0; k < 20; k++) begin
            bus(1'b1, wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, 32'h1 << k);
            exp_pkt.push_back(20'h1 << k);
            fire((20'h1 << k) | (20'h1 << ((k + 5) % 20)));
            poll(4'(k));
            poll(4'h0);
        end
        bus(1'b1, wkirq_pkg::INTERRUPT_ENDPOINT_CONTROL_OFS, 32'h8000_0000);
        exp_pkt.push_back(20'h0);
        poll(4'h0);
        bus(1'b1, wkirq_pkg::IRQ_CLEAR_OFS, 32'h3);
        bus(1'b1, wkirq_pkg::IRQ_ENABLE_OFS, 32'h2);
        exp_pkt.push_back(20'h0);
        poll(4'h2);
        chk(1'b1, 1'b1);
        rd(wkirq_pkg::IRQ_STATUS_OFS, 32'h2);
        bus(1'b1, wkirq_pkg::IRQ_ENABLE_OFS, 32'h0);
        chk(1'b1, 1'b0);
        bus(1'b1, wkirq_pkg::IRQ_ENABLE_OFS, 32'h2);
        chk(1'b1, 1'b1);
        bus(1'b1, wkirq_pkg::IRQ_CLEAR_OFS, 32'h2);
        chk(1'b1, 1'b0);
        rd(wkirq_pkg::IRQ_STATUS_OFS, 32'h0);
        rd(wkirq_pkg::IRQ_CLEAR_OFS, 32'h0);
        rd(wkirq_pkg::IRQ_ENABLE_OFS, 32'h2);
        repeat (3) @(posedge clk_i);
        cmp_lvl(exp_pkt.size() == 0 && exp_rd.size() == 0, 1'b1);
        complete_run();
    end
endmodule : wkirq_top_tb
